// ==== core/buf_ctl.sv ====
// data buffer control: steering, latch strobes and posted-buffer pointers
// Functional notes
// R01: steer code 00 float,01 ones,10 pci,11 mem
// R02: pci latch captures host/memory for pci reads
// R03: pci latch captures AD for cpu reads
// R04: pci latch captures AD into pci post buffer
// R05: AD output enable on cpu-write-pci, pci-read-mem
// R06: memory latch negated to capture memory data
// R07: pci push stores host word, advances write
// R08: pci pop advances the read pointer
// R09: memory push each processor edge advances write
// R10: memory pop each processor edge advances read
// R11: prelatch captures buffer head onto AD
// R12: prelatch on pci reads cache, writes memory
// R13: high dword flag in four transfer cases
// R14: pci-side strobes run from pci clock; here only cpu-read-pci and pci-write-mem wait for a pci clock rise
// R15: never pop empty, never push full
`timescale 1ns/100ps
module buf_ctl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic pci_clock_in_i,
  input buf_ctl_pkg::cmd_type cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output buf_ctl_pkg::strobe_type strobe_o,
  output logic pci_side_latch_enable_n_o,
  output logic [2:0] pci_fill_o,
  output logic [2:0] mem_fill_o
);
  import buf_ctl_pkg::*;

  // the companion chip steps its pci-side pointers on strobe edges, so a
  // push or pop pulse must fall back low for a cycle before it rises again;
  // the memory-side strobes are sampled as levels and may repeat back to back.
  // fills are pointer differences with a wrap bit, which tells a full buffer
  // (a fill of four) apart from an empty one.

  // two-entry command buffer
  cmd_type slot_r [2];
  logic [1:0] count_r;
  logic wr_sel_r;
  logic rd_sel_r;
  logic push_in;
  logic pop_out;
  cmd_type head;
  logic head_valid;
  logic head_ok;

  // pci clock sampled through two flops, then edge detected
  logic pclk_s1_r;
  logic pclk_s2_r;
  logic pclk_s3_r;
  logic pclk_rise;

  // posted buffer pointers with wrap bit
  logic [2:0] pci_wr_r;
  logic [2:0] pci_rd_r;
  logic [2:0] mem_wr_r;
  logic [2:0] mem_rd_r;
  strobe_type strobe_r;
  strobe_type strobe_nxt;
  logic latch_n_r;
  logic latch_n_nxt;

  // occupancy of a pointer pair
  function automatic logic [2:0] fill_of(input logic [2:0] wr, input logic [2:0] rd);
    fill_of = wr - rd;
  endfunction

  // transfers whose latching must line up with a pci clock rise
  function automatic logic waits_pci_clock(input op_type op);
    waits_pci_clock = (op == OP_CPU_RD_PCI) || (op == OP_PCI_WR_MEM);
  endfunction

  assign cmd_ready_o = (count_r != 2'h2);
  assign push_in = cmd_valid_i && cmd_ready_o;
  assign head = slot_r[rd_sel_r];
  assign head_valid = (count_r != 2'h0);
  assign pci_fill_o = fill_of(pci_wr_r, pci_rd_r);
  assign mem_fill_o = fill_of(mem_wr_r, mem_rd_r);

  // a head that would overfill or underflow a buffer stalls here
  always_comb begin
    head_ok = 1'b1;
    if ((head.op == OP_CPU_WR_PCI) && (pci_fill_o == 3'(POST_DEPTH))) head_ok = 1'b0; // R15
    if ((head.op == OP_CPU_WR_MEM) && (mem_fill_o == 3'(POST_DEPTH))) head_ok = 1'b0; // R15
    if (head.drain_pci && (pci_fill_o == 3'h0)) head_ok = 1'b0; // R15
    if (head.drain_mem && (mem_fill_o == 3'h0)) head_ok = 1'b0; // R15
    // edge-counted strobes: leave one low cycle between two pulses
    if ((head.op == OP_CPU_WR_PCI) && strobe_r.cpu_to_pci_push) head_ok = 1'b0; // R07
    if (head.drain_pci && strobe_r.cpu_to_pci_pop) head_ok = 1'b0; // R08
  end

  // pci-side latching for cpu-read-pci and pci-write-mem waits for a pci clock rise
  always_comb begin
    pop_out = head_valid && head_ok;
    if (waits_pci_clock(head.op)) pop_out = pop_out && pclk_rise; // R14
  end

  // command buffer storage
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else if (push_in) begin
      slot_r[wr_sel_r] <= cmd_i;
    end
  end

  // command buffer pointers and count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= CMD_SLOT_RESET;
      wr_sel_r <= 1'b0;
      rd_sel_r <= 1'b0;
    end else begin
      if (push_in) wr_sel_r <= ~wr_sel_r;
      if (pop_out) rd_sel_r <= ~rd_sel_r;
      if (push_in && !pop_out) count_r <= count_r + 2'h1;
      else if (!push_in && pop_out) count_r <= count_r - 2'h1;
    end
  end

  // pci clock synchroniser and edge history; only the second flop feeds the
  // third, so a metastable first stage never reaches the edge detector
  // directly
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
    end else begin
      pclk_s1_r <= pci_clock_in_i;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
    end
  end
  assign pclk_rise = pclk_s2_r && !pclk_s3_r; // R14

  // decode the issued command into one cycle of strobes; pops ride along on
  // any command through its drain bits, and the memory read latch enable sits
  // high between transfers so the chip keeps the last memory word
  always_comb begin
    strobe_nxt = '0;
    strobe_nxt.memory_read_latch_enable = 1'b1; // hold memory data when idle
    latch_n_nxt = 1'b1;
    if (pop_out) begin
      strobe_nxt.cpu_to_pci_pop = head.drain_pci; // R08
      strobe_nxt.cpu_to_mem_pop = head.drain_mem; // R10
      case (head.op)
        OP_CPU_WR_PCI: begin
          strobe_nxt.cpu_to_pci_push = 1'b1; // R07
          strobe_nxt.pci_bus_output_enable = 1'b1; // R05
          strobe_nxt.high_dword_flag = head.high_dword; // R13
        end
        OP_CPU_RD_PCI: begin
          latch_n_nxt = 1'b0; // R03
          strobe_nxt.host_bus_steer_code = STEER_PCI; // R01
          strobe_nxt.high_dword_flag = head.high_dword; // R13
        end
        OP_CPU_WR_MEM: begin
          strobe_nxt.cpu_to_mem_push = 1'b1; // R09
        end
        OP_CPU_RD_MEM: begin
          strobe_nxt.memory_read_latch_enable = 1'b0; // R06
          strobe_nxt.host_bus_steer_code = STEER_MEM; // R01
        end
        OP_PCI_RD_MEM: begin
          strobe_nxt.memory_read_latch_enable = 1'b0; // R06
          latch_n_nxt = 1'b0; // R02
          strobe_nxt.pci_bus_output_enable = 1'b1; // R05
          strobe_nxt.high_dword_flag = head.high_dword; // R13
        end
        OP_PCI_WR_MEM: begin
          latch_n_nxt = 1'b0; // R04
          strobe_nxt.prelatch_enable = 1'b1; // R12
          strobe_nxt.high_dword_flag = head.high_dword; // R13
        end
        OP_PCI_RD_L2: begin
          latch_n_nxt = 1'b0; // R02
          strobe_nxt.prelatch_enable = 1'b1; // R11
          strobe_nxt.host_bus_steer_code = STEER_FLOAT; // R01
        end
        default: begin
          strobe_nxt.host_bus_steer_code = STEER_FLOAT;
        end
      endcase
    end
  end

  // registered strobe outputs, so the chip sees clean levels
  // with no decode glitches
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_r <= '0;
      latch_n_r <= 1'b1;
    end else begin
      strobe_r <= strobe_nxt;
      latch_n_r <= latch_n_nxt;
    end
  end
  assign strobe_o = strobe_r;
  assign pci_side_latch_enable_n_o = latch_n_r;

  // mirrors of the companion chip's posted buffer pointers; they step with
  // the strobe register, so the fills change on the edge a strobe appears
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pci_wr_r <= PTR_RESET;
      pci_rd_r <= PTR_RESET;
      mem_wr_r <= PTR_RESET;
      mem_rd_r <= PTR_RESET;
    end else begin
      if (strobe_nxt.cpu_to_pci_push) pci_wr_r <= pci_wr_r + 3'h1; // R07
      if (strobe_nxt.cpu_to_pci_pop) pci_rd_r <= pci_rd_r + 3'h1; // R08
      if (strobe_nxt.cpu_to_mem_push) mem_wr_r <= mem_wr_r + 3'h1; // R09
      if (strobe_nxt.cpu_to_mem_pop) mem_rd_r <= mem_rd_r + 3'h1; // R10
    end
  end
endmodule

// ==== core/buf_ctl_pkg.sv ====
// package for the data buffer control block: codes, depths, command layout
package buf_ctl_pkg;
  // host bus steering encodings
  localparam logic [1:0] STEER_FLOAT = 2'h0;
  localparam logic [1:0] STEER_ONES = 2'h1;
  localparam logic [1:0] STEER_PCI = 2'h2;
  localparam logic [1:0] STEER_MEM = 2'h3;
  // depth of each posted write buffer in the companion chip
  localparam int unsigned POST_DEPTH = 4;
  localparam int unsigned PTR_W = 3;
  localparam logic [2:0] PTR_RESET = 3'h0;
  localparam logic [1:0] CMD_SLOT_RESET = 2'h0;
  // transfer kinds requested by the controller core
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_CPU_WR_PCI = 3'h1,
    OP_CPU_RD_PCI = 3'h3,
    OP_CPU_WR_MEM = 3'h2,
    OP_CPU_RD_MEM = 3'h6,
    OP_PCI_RD_MEM = 3'h7,
    OP_PCI_WR_MEM = 3'h5,
    OP_PCI_RD_L2 = 3'h4
  } op_type;
  // one data-phase command
  typedef struct packed {
    op_type op;
    logic high_dword;
    logic drain_pci;
    logic drain_mem;
  } cmd_type;
  // strobes to the companion chip
  typedef struct packed {
    logic [1:0] host_bus_steer_code;
    logic pci_bus_output_enable;
    logic memory_read_latch_enable;
    logic cpu_to_pci_push;
    logic cpu_to_pci_pop;
    logic cpu_to_mem_push;
    logic cpu_to_mem_pop;
    logic prelatch_enable;
    logic high_dword_flag;
  } strobe_type;
endpackage

// ==== bench/buf_ctl_checker.sv ====
// checker for the buffer control strobes and fill counts
`timescale 1ns/100ps
module buf_ctl_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input buf_ctl_pkg::strobe_type strobe_o,
  input wire logic pci_side_latch_enable_n_o,
  input wire logic [2:0] pci_fill_o,
  input wire logic [2:0] mem_fill_o
);
  import buf_ctl_pkg::*;
  strobe_type s;
  wire logic ln;
  assign s = strobe_o;
  assign ln = pci_side_latch_enable_n_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // output enable, prelatch, pci steering, memory latch and dword flag need their cause, fills move by exactly one
  a_oe_cause: assert property (s.pci_bus_output_enable |-> s.cpu_to_pci_push || !ln) else $error("oe");
  a_pci_push: assert property (s.cpu_to_pci_push && !s.cpu_to_pci_pop |->
    pci_fill_o == $past(pci_fill_o) + 3'h1) else $error("pci fill");
  a_mem_push: assert property (s.cpu_to_mem_push && !s.cpu_to_mem_pop |->
    mem_fill_o == $past(mem_fill_o) + 3'h1) else $error("mem fill");
  a_mem_pop: assert property (s.cpu_to_mem_pop && !s.cpu_to_mem_push |->
    mem_fill_o == $past(mem_fill_o) - 3'h1) else $error("mem pop");
  a_pci_pop: assert property (s.cpu_to_pci_pop && !s.cpu_to_pci_push |->
    pci_fill_o == $past(pci_fill_o) - 3'h1) else $error("pci pop");
  a_push_gap: assert property (s.cpu_to_pci_push |=> !s.cpu_to_pci_push) else $error("push gap");
  a_pop_gap: assert property (s.cpu_to_pci_pop |=> !s.cpu_to_pci_pop) else $error("pop gap");
  a_pre_latch: assert property (s.prelatch_enable |-> !ln) else $error("prelatch");
  a_steer_pci: assert property (s.host_bus_steer_code == STEER_PCI |-> !ln) else $error("steer");
  a_mem_capture: assert property (!s.memory_read_latch_enable && $past(resetn_i) |->
    s.host_bus_steer_code == STEER_MEM || s.pci_bus_output_enable) else $error("mem latch");
  a_flag_cause: assert property (s.high_dword_flag |-> s.cpu_to_pci_push || !ln) else $error("flag");
endmodule

// ==== bench/buf_chip_model.sv ====
// companion chip model: occupancy of both posted write buffers
`timescale 1ns/100ps
module buf_chip_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input buf_ctl_pkg::strobe_type strobe_i,
  output logic [2:0] pci_cnt_o,
  output logic [2:0] mem_cnt_o
);
  import buf_ctl_pkg::*;
  logic push_d_r;
  logic pop_d_r;
  // pci side counts rising edges of its strobes, memory side counts levels
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pci_cnt_o <= 3'h0;
      mem_cnt_o <= 3'h0;
      push_d_r <= 1'b0;
      pop_d_r <= 1'b0;
    end else begin
      push_d_r <= strobe_i.cpu_to_pci_push;
      pop_d_r <= strobe_i.cpu_to_pci_pop;
      pci_cnt_o <= pci_cnt_o + {2'h0, strobe_i.cpu_to_pci_push & ~push_d_r} -
        {2'h0, strobe_i.cpu_to_pci_pop & ~pop_d_r};
      mem_cnt_o <= mem_cnt_o + {2'h0, strobe_i.cpu_to_mem_push} - {2'h0, strobe_i.cpu_to_mem_pop};
    end
  end
endmodule

// ==== bench/buf_ctl_tb.sv ====
// testbench for the data buffer control block
`timescale 1ns/100ps
module buf_ctl_tb;
  import buf_ctl_pkg::*;
  logic clk_i = 0, pci_clock_in_i = 0, resetn_i = 0, cmd_valid_i = 0;
  cmd_type cmd_i = '0;
  logic cmd_ready_o, ln, lt, hit;
  strobe_type strobe_o, st;
  logic [2:0] pci_fill_o, mem_fill_o, pci_cnt, mem_cnt;
  logic [6:0] g;
  int fail_count = 0, checked = 0;
  buf_ctl buf_ctl_i(.clk_i, .resetn_i, .pci_clock_in_i, .cmd_i, .cmd_valid_i, .cmd_ready_o, .strobe_o,
    .pci_side_latch_enable_n_o(ln), .pci_fill_o, .mem_fill_o);
  buf_chip_model buf_chip_model_i(.clk_i, .resetn_i, .strobe_i(strobe_o), .pci_cnt_o(pci_cnt), .mem_cnt_o(mem_cnt));
  // processor clock 40 ns, pci clock 30 ns with its own phase
  initial forever #20 clk_i = ~clk_i;
  initial begin
    #7;
    forever #15 pci_clock_in_i = ~pci_clock_in_i;
  end
  task check(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task do_reset;
    resetn_i = 0;
    repeat (16) @(posedge clk_i);
    #1 resetn_i = 1;
  endtask
  // offer one command and hold it until taken
  task send(input op_type op, input logic hd, dp, dm);
    @(posedge clk_i) #1;
    cmd_i = '{op, hd, dp, dm};
    cmd_valid_i = 1;
    while (cmd_ready_o !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    cmd_valid_i = 0;
  endtask
  // capture the first cycle with any strobe active
  task watch(input int n);
    hit = 0;
    repeat (n) begin
      @(posedge clk_i) #1;
      if (!hit && (strobe_o !== 10'h040 || ln !== 1'b1)) begin
        hit = 1;
        st = strobe_o;
        lt = ln;
      end
    end
  endtask
  // five transfer kinds (all but the two cpu writes) against their expected strobe sets
  task t_ops;
    op_type ops [5] = '{OP_CPU_RD_PCI, OP_CPU_RD_MEM, OP_PCI_RD_MEM, OP_PCI_WR_MEM, OP_PCI_RD_L2};
    logic [6:0] ex [5] = '{7'h49, 7'h62, 7'h11, 7'h0d, 7'h0c};
    for (int k = 0; k < 5; k++) begin
      send(ops[k], 1, 0, 0);
      watch(20);
      g = {st.host_bus_steer_code, st.pci_bus_output_enable, st.memory_read_latch_enable, st.prelatch_enable, lt,
        st.high_dword_flag};
      check(hit === 1'b1 && g === ex[k], "strobe set");
    end
  endtask
  // four pushes fill the buffer, a fifth is held back
  task t_fill;
    for (int i = 0; i < 4; i++) begin
      send(OP_CPU_WR_PCI, i[0], 0, 0);
      watch(12);
      check(hit === 1'b1 && st.cpu_to_pci_push === 1'b1 && st.pci_bus_output_enable === 1'b1, "push");
      check(st.high_dword_flag === i[0], "flag");
    end
    check(pci_fill_o === 3'h4 && pci_cnt === 3'h4, "full");
    send(OP_CPU_WR_PCI, 0, 0, 0);
    watch(20);
    check(hit === 1'b0, "push into full");
    send(OP_CPU_WR_PCI, 0, 0, 0);
    check(cmd_ready_o === 1'b0, "command buffer full");
  endtask
  // put one word in the pci buffer and two in the memory buffer, then pop both in one command
  task t_drain;
    send(OP_CPU_WR_PCI, 1, 0, 0);
    send(OP_CPU_WR_MEM, 0, 0, 0);
    send(OP_CPU_WR_MEM, 0, 0, 0);
    repeat (8) @(posedge clk_i);
    check(pci_fill_o === 3'h1 && mem_fill_o === 3'h2 && mem_cnt === 3'h2, "fill");
    send(OP_IDLE, 0, 1, 1);
    watch(12);
    check(st.cpu_to_pci_pop === 1'b1 && st.cpu_to_mem_pop === 1'b1, "pop");
    check(pci_fill_o === 3'h0 && mem_fill_o === 3'h1 && pci_cnt === 3'h0 && mem_cnt === 3'h1, "drain");
  endtask
  // two pushes offered back to back must reach the chip as two separate edges
  task t_burst;
    @(posedge clk_i) #1;
    cmd_i = '{OP_CPU_WR_PCI, 1'b0, 1'b0, 1'b0};
    cmd_valid_i = 1;
    while (cmd_ready_o !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    cmd_i = '{OP_CPU_WR_PCI, 1'b1, 1'b0, 1'b0};
    while (cmd_ready_o !== 1'b1) @(posedge clk_i) #1;
    @(posedge clk_i) #1;
    cmd_valid_i = 0;
    repeat (8) @(posedge clk_i);
    check(pci_fill_o === 3'h2 && pci_cnt === 3'h2, "burst push");
  endtask
  task summarize;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    do_reset;
    t_ops;
    t_fill;
    do_reset;
    t_drain;
    t_burst;
    summarize;
  end
  // watchdog well beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
endmodule
bind buf_ctl buf_ctl_checker buf_ctl_checker_i(.clk_i, .resetn_i, .strobe_o, .pci_side_latch_enable_n_o,
  .pci_fill_o, .mem_fill_o);
